// ===== pkg/aux_seq_map.svh
// Constants of the status indicator and mode sequencer.
`ifndef AUX_SEQ_MAP_SVH
`define AUX_SEQ_MAP_SVH
// Function
// - Two mode-select inputs together choose one of four working modes.
// - Encoding hi,lo: 00 normal, 01 wake, 10 configuration, 11 deep sleep.
// - Indicator stays low for the whole self-check.
// - At power-up indicator low, self-check, load parameters, then high in pin mode.
// - Self-check only at power-on or when leaving sleep.
// - Leaving sleep reloads parameters with the indicator held low.
// - Own address all ones makes transmitted data a broadcast.
// - Own address all ones accepts received data for any destination.
// - Transmit buffer holds 1000 bytes; high indicator means it is empty.
// - Low indicator means data still buffered; host should hold off.
// - Buffered data is cut into radio sub-packets automatically.
// - Buffer counts empty once the last sub-packet reaches the radio.
// - Indicator low also while received data awaits serial output.
// - Indicator is low when any busy condition holds, else high.
// - Mode pins ignored while busy; pending switch completes after going high.
// - After busy, new mode takes effect once high for 2 ms.

// ****************************************************************
// Timing
// ****************************************************************
`define AUX_CLK_PERIOD_NS 10
`define AUX_SETTLE_TIME_NS 2000000
`define AUX_SETTLE_CYCLES ((`AUX_SETTLE_TIME_NS + `AUX_CLK_PERIOD_NS - 1) / `AUX_CLK_PERIOD_NS)
`define AUX_INIT_CYCLES 1000

// ****************************************************************
// Sizes and addresses
// ****************************************************************
`define AUX_BYTE_W 8
`define AUX_ADDR_W 16
`define AUX_TX_BUF_BYTES 1000
`define AUX_RX_FIFO_WORDS 32
`define AUX_SUBPKT_BYTES 240
`define AUX_BCAST_ADDR 16'hffff

`endif

// ===== pkg/aux_seq_pkg.sv
// Types shared by the status indicator and mode sequencer.
`include "aux_seq_map.svh"
package aux_seq_pkg;
	// Working modes as decoded from the select pins.
	typedef enum logic [1:0] {
		MODE_NORMAL = 2'b00,
		MODE_WAKE = 2'b01,
		MODE_CONFIG = 2'b10,
		MODE_SLEEP = 2'b11
	} mode_t;
	// Sequencer phases.
	typedef enum logic [1:0] {
		ST_SELFCHECK = 2'b00,
		ST_RELOAD = 2'b01,
		ST_RUN = 2'b10
	} seq_state_t;
	// Byte handed to the radio.
	typedef struct packed {
		logic [`AUX_BYTE_W-1:0] data;
		logic last;
		logic broadcast;
	} radio_tx_t;
	// Byte taken from the radio with its destination address.
	typedef struct packed {
		logic [`AUX_BYTE_W-1:0] data;
		logic [`AUX_ADDR_W-1:0] dest_addr;
	} radio_rx_t;
	// Conditions that pull the indicator low.
	typedef struct packed {
		logic init_busy;
		logic tx_pending;
		logic rx_pending;
	} busy_cond_t;
endpackage : aux_seq_pkg

// ===== design/mode_sync.sv
// Two-stage synchroniser and decoder for the mode-select pins.
`timescale 1ns/1ps
`default_nettype none
module mode_sync import aux_seq_pkg::*; (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Pins
	input wire logic mode_select_lo_i,
	input wire logic mode_select_hi_i,
	// Decoded mode
	output mode_t sel_mode_o
);
	logic [1:0] pins;
	logic [1:0] stage1;
	logic [1:0] stage2;

	assign pins = {mode_select_hi_i, mode_select_lo_i};

	// Each pin gets its own two flops; only stage2 is read onward.
	for (genvar i = 0; i < 2; i++) begin : g_sync
		always_ff @(posedge clk_i or negedge rst_b_i) begin
			if (!rst_b_i) begin
				stage1[i] <= 1'b0;
				stage2[i] <= 1'b0;
			end else begin
				stage1[i] <= pins[i];
				stage2[i] <= stage1[i];
			end
		end
	end

	// High select bit first gives the mode number directly.
	assign sel_mode_o = mode_t'(stage2);
endmodule : mode_sync
`default_nettype wire

// ===== design/byte_fifo.sv
// Synchronous FIFO with a registered read stage.
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Fill side
	input wire logic in_valid_i,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic in_ready_o,
	// Drain side
	output logic out_valid_o,
	output logic [WIDTH-1:0] out_data_o,
	input wire logic out_ready_i,
	// Occupancy
	output logic [$clog2(DEPTH+2)-1:0] level_o
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+2);
	localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH-1);
	localparam logic [CW-1:0] CAP = CW'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [CW-1:0] mem_cnt;
	logic push;
	logic pop;

	// Wrap that also works for depths that are not a power of two.
	function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
		next_ptr = (p == LAST_IDX) ? '0 : p + 1'b1;
	endfunction : next_ptr

	// The output register counts toward capacity so full is honest.
	assign level_o = mem_cnt + CW'(out_valid_o);
	assign in_ready_o = level_o < CAP;
	assign push = in_valid_i && in_ready_o;
	assign pop = (mem_cnt != '0) && (!out_valid_o || out_ready_i);

	// Storage array, no reset needed.
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	// Pointers and count.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			mem_cnt <= '0;
		end else begin
			if (push) begin
				wr_ptr <= next_ptr(wr_ptr);
			end
			if (pop) begin
				rd_ptr <= next_ptr(rd_ptr);
			end
			mem_cnt <= mem_cnt + CW'(push) - CW'(pop);
		end
	end

	// Registered read stage.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			out_valid_o <= 1'b0;
			out_data_o <= '0;
		end else if (pop) begin
			out_valid_o <= 1'b1;
			out_data_o <= mem[rd_ptr];
		end else if (out_ready_i) begin
			out_valid_o <= 1'b0;
		end
	end
endmodule : byte_fifo
`default_nettype wire

// ===== design/aux_status_mode_sequencer.sv
// Busy indicator, mode sequencing and addressing of the serial radio module.
`timescale 1ns/1ps
`default_nettype none
module aux_status_mode_sequencer import aux_seq_pkg::*; #(
	parameter int SETTLE_CYCLES = `AUX_SETTLE_CYCLES,
	parameter int INIT_CYCLES = `AUX_INIT_CYCLES,
	parameter int TX_BUF_BYTES = `AUX_TX_BUF_BYTES,
	parameter int RX_FIFO_WORDS = `AUX_RX_FIFO_WORDS,
	parameter int SUBPKT_BYTES = `AUX_SUBPKT_BYTES
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Mode pins from the host
	input wire logic mode_select_lo_i,
	input wire logic mode_select_hi_i,
	// Stored own address
	input wire logic [`AUX_ADDR_W-1:0] own_addr_i,
	// Serial input bytes
	input wire logic [`AUX_BYTE_W-1:0] ser_in_data_i,
	input wire logic ser_in_valid_i,
	output logic ser_in_ready_o,
	// Serial output bytes
	output logic [`AUX_BYTE_W-1:0] ser_out_data_o,
	output logic ser_out_valid_o,
	input wire logic ser_out_ready_i,
	input wire logic ser_out_active_i,
	// Radio transmit side
	output radio_tx_t radio_tx_o,
	output logic radio_tx_valid_o,
	input wire logic radio_tx_ready_i,
	// Radio receive side
	input wire radio_rx_t radio_rx_i,
	input wire logic radio_rx_valid_i,
	output logic radio_rx_ready_o,
	// Status
	output logic idle_ind_o,
	output mode_t mode_o
);
	// ****************************************************************
	// Declarations
	// ****************************************************************
	localparam int HW = $clog2(SETTLE_CYCLES+1);
	localparam int IW = $clog2(INIT_CYCLES+1);
	localparam int SW = $clog2(SUBPKT_BYTES+1);
	localparam int TLW = $clog2(TX_BUF_BYTES+2);
	localparam int RLW = $clog2(RX_FIFO_WORDS+2);
	localparam logic [HW-1:0] SETTLE_MAX = HW'(SETTLE_CYCLES);
	localparam logic [IW-1:0] INIT_LAST = IW'(INIT_CYCLES-1);
	localparam logic [SW-1:0] SUB_LAST = SW'(SUBPKT_BYTES-1);
	localparam logic [TLW-1:0] TX_ONE = TLW'(1);

	mode_t sel_mode;
	seq_state_t state;
	logic [IW-1:0] init_cnt;
	logic [HW-1:0] high_cnt;
	logic [SW-1:0] sub_cnt;
	logic bcast_tx;
	logic init_done;
	logic do_switch;
	busy_cond_t busy;
	logic radio_on;
	logic tx_in_ready;
	logic tx_out_valid;
	logic tx_out_ready;
	logic [`AUX_BYTE_W-1:0] tx_out_data;
	logic [TLW-1:0] tx_level;
	logic rx_in_valid;
	logic rx_in_ready;
	logic [RLW-1:0] rx_level;
	logic rx_match;
	logic tx_take;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	// Host input and radio reception are only open in the two data modes.
	function automatic logic is_data_mode(input mode_t m);
		is_data_mode = (m == MODE_NORMAL) || (m == MODE_WAKE);
	endfunction : is_data_mode

	// Own address all ones listens to every destination.
	function automatic logic addr_match(
		input logic [`AUX_ADDR_W-1:0] own,
		input logic [`AUX_ADDR_W-1:0] dest
	);
		addr_match = (own == `AUX_BCAST_ADDR) || (dest == `AUX_BCAST_ADDR) || (dest == own);
	endfunction : addr_match

	// ****************************************************************
	// Pin synchroniser and buffers
	// ****************************************************************
	mode_sync u_sync (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.mode_select_lo_i(mode_select_lo_i),
		.mode_select_hi_i(mode_select_hi_i),
		.sel_mode_o(sel_mode)
	);

	// Transmit buffer between the serial input and the radio.
	byte_fifo #(
		.WIDTH(`AUX_BYTE_W),
		.DEPTH(TX_BUF_BYTES)
	) u_tx_buf (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.in_valid_i(ser_in_valid_i && radio_on),
		.in_data_i(ser_in_data_i),
		.in_ready_o(tx_in_ready),
		.out_valid_o(tx_out_valid),
		.out_data_o(tx_out_data),
		.out_ready_i(tx_out_ready),
		.level_o(tx_level)
	);

	// Receive FIFO between the radio and the serial output.
	byte_fifo #(
		.WIDTH(`AUX_BYTE_W),
		.DEPTH(RX_FIFO_WORDS)
	) u_rx_buf (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.in_valid_i(rx_in_valid),
		.in_data_i(radio_rx_i.data),
		.in_ready_o(rx_in_ready),
		.out_valid_o(ser_out_valid_o),
		.out_data_o(ser_out_data_o),
		.out_ready_i(ser_out_ready_i),
		.level_o(rx_level)
	);

	// ****************************************************************
	// Data paths
	// ****************************************************************
	// A full buffer stalls the host; nothing is accepted outside data modes.
	// The host sees the stall at once because ready is combinational, so no
	// byte is ever lost to a late refusal.
	assign radio_on = (state == ST_RUN) && is_data_mode(mode_o);
	assign ser_in_ready_o = tx_in_ready && radio_on;

	// Buffered data drains to the radio whatever the mode, so a switch
	// into sleep still sends what the host already wrote.
	assign tx_out_ready = radio_tx_ready_i && (state == ST_RUN);
	assign radio_tx_valid_o = tx_out_valid && (state == ST_RUN);
	assign tx_take = radio_tx_valid_o && radio_tx_ready_i;
	assign radio_tx_o.data = tx_out_data;
	assign radio_tx_o.last = (sub_cnt == SUB_LAST) || (tx_level == TX_ONE);
	assign radio_tx_o.broadcast = bcast_tx;

	// Bytes for other stations are dropped with ready held high.
	assign rx_match = addr_match(own_addr_i, radio_rx_i.dest_addr);
	assign rx_in_valid = radio_rx_valid_i && radio_on && rx_match;
	assign radio_rx_ready_o = radio_on && (rx_in_ready || !rx_match);

	// Sub-packet byte counter; a packet also closes when the buffer runs dry.
	// A slow host can therefore produce short packets, which costs air time.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sub_cnt <= '0;
		end else if (tx_take) begin
			sub_cnt <= radio_tx_o.last ? '0 : sub_cnt + 1'b1;
		end
	end

	// Broadcast flag follows the stored address.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			bcast_tx <= 1'b0;
		end else begin
			bcast_tx <= (own_addr_i == `AUX_BCAST_ADDR);
		end
	end

	// ****************************************************************
	// Busy indicator
	// ****************************************************************
	// The buffer counts as empty once its last byte has gone to the
	// radio, even if that packet is still on air.
	assign busy.init_busy = (state != ST_RUN);
	assign busy.tx_pending = (tx_level != '0);
	assign busy.rx_pending = (rx_level != '0) || ser_out_active_i;

	// Registered so the pin never glitches; any condition pulls it low.
	// The cost is one cycle of lag behind the conditions themselves.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			idle_ind_o <= 1'b0;
		end else begin
			idle_ind_o <= !(|busy);
		end
	end

	// Time since the rising edge, saturating at the settle time.
	// Saturation keeps the counter small and marks a long idle stretch.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			high_cnt <= '0;
		end else if (!idle_ind_o) begin
			high_cnt <= '0;
		end else if (high_cnt != SETTLE_MAX) begin
			high_cnt <= high_cnt + 1'b1;
		end
	end

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	// Once running, pins are looked at only while idle and settled; a saturated count
	// means the indicator was already high, so the switch is immediate.
	assign init_done = (state != ST_RUN) && (init_cnt == INIT_LAST);
	assign do_switch = (state == ST_RUN) && idle_ind_o && (high_cnt == SETTLE_MAX)
		&& (sel_mode != mode_o);

	// Self-check and parameter reload length.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			init_cnt <= '0;
		end else if (state == ST_RUN || init_done) begin
			init_cnt <= '0;
		end else begin
			init_cnt <= init_cnt + 1'b1;
		end
	end

	// Phase machine: ordinary switches never re-run the self-check.
	// Leaving sleep passes through the reload phase so that stored
	// parameters are applied again before any data moves.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state <= ST_SELFCHECK;
		end else begin
			unique case (state)
				ST_SELFCHECK, ST_RELOAD: begin
					if (init_done) begin
						state <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (do_switch && mode_o == MODE_SLEEP) begin
						state <= ST_RELOAD;
					end
				end
				default: begin
					state <= ST_SELFCHECK;
				end
			endcase
		end
	end

	// Working mode: taken from the pins after self-check or on a switch.
	// The reload phase keeps the mode that the switch out of sleep chose.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mode_o <= MODE_NORMAL;
		end else if (state == ST_SELFCHECK && init_done) begin
			mode_o <= sel_mode;
		end else if (do_switch) begin
			mode_o <= sel_mode;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	// All checks run on the module clock and stay quiet while reset is low.
	// Registered outputs are judged one edge after the conditions behind them.
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	a_init_holds_low: assert property (state != ST_RUN |=> !idle_ind_o)
		else $error("indicator high during self-check");

	a_busy_or_cond: assert property (1'b1 |=> idle_ind_o == !$past(|busy))
		else $error("indicator does not follow busy conditions");

	a_rise_needs_idle: assert property ($rose(idle_ind_o) |-> $past(state) == ST_RUN
		&& $past(tx_level) == '0 && !$past(ser_out_active_i))
		else $error("indicator rose while busy");

	a_rx_pending_low: assert property (ser_out_valid_o || ser_out_active_i |=> !idle_ind_o)
		else $error("indicator high with serial output pending");

	a_tx_pending_low: assert property (tx_out_valid |=> !idle_ind_o)
		else $error("indicator high with buffered data");

	a_no_eval_busy: assert property (!idle_ind_o && state == ST_RUN |=> $stable(mode_o))
		else $error("mode changed while busy");

	a_switch_settle: assert property (state == ST_RUN && high_cnt != SETTLE_MAX
		|=> $stable(mode_o))
		else $error("mode changed before settle time");

	a_switch_prompt: assert property (state == ST_RUN && idle_ind_o && high_cnt == SETTLE_MAX
		&& sel_mode != mode_o |=> mode_o == $past(sel_mode))
		else $error("settled mode switch not applied");

	a_pin_decode: assert property (1'b1 |-> ##2 sel_mode
		== mode_t'($past({mode_select_hi_i, mode_select_lo_i}, 2)))
		else $error("mode pins decoded wrongly");

	a_sleep_exit_reload: assert property (state == ST_RUN && mode_o == MODE_SLEEP
		##1 mode_o != MODE_SLEEP |-> state == ST_RELOAD)
		else $error("no reload on leaving sleep");

	a_no_check_other: assert property (state == ST_RUN && mode_o != MODE_SLEEP |=> state == ST_RUN)
		else $error("self-check outside power-on or sleep exit");

	a_monitor_rx: assert property (radio_rx_valid_i && radio_on
		&& own_addr_i == `AUX_BCAST_ADDR |-> rx_in_valid)
		else $error("monitor address dropped a byte");

	a_bcast_tx: assert property ($stable(own_addr_i) && radio_tx_valid_o
		|-> radio_tx_o.broadcast == (own_addr_i == `AUX_BCAST_ADDR))
		else $error("broadcast flag wrong");

	a_subpkt_len: assert property (tx_take && sub_cnt == SUB_LAST |=> sub_cnt == '0)
		else $error("sub-packet too long");

	a_host_stall: assert property (!tx_in_ready |-> !ser_in_ready_o)
		else $error("host accepted with full buffer");

	a_buf_cap: assert property (tx_level <= TLW'(TX_BUF_BYTES))
		else $error("transmit buffer over capacity");

	a_last_on_empty: assert property (tx_take && tx_level == TX_ONE |-> radio_tx_o.last)
		else $error("final buffered byte not marked last");

	a_mode_frozen: assert property (state != ST_RUN && !init_done |=> $stable(mode_o))
		else $error("mode changed during self-check");

	a_reload_quiet: assert property (state != ST_RUN
		|-> !ser_in_ready_o && !radio_rx_ready_o && !radio_tx_valid_o)
		else $error("data moved during self-check");

	// Main scenarios that the bench is expected to reach.
	c_ready_rise: cover property ($rose(idle_ind_o));
	c_enter_sleep: cover property (do_switch && sel_mode == MODE_SLEEP);
	c_reload: cover property (state == ST_RELOAD ##1 state == ST_RUN);
	c_buf_full: cover property (ser_in_valid_i && radio_on && !tx_in_ready);
	c_broadcast: cover property (tx_take && radio_tx_o.broadcast && radio_tx_o.last);
endmodule : aux_status_mode_sequencer
`default_nettype wire

// ===== sim/host_model.sv
// Host controller model that streams bytes in and takes bytes out.
`timescale 1ns/1ps
`default_nettype none
module host_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Control from the bench
	input wire logic stall_i,
	// Bytes towards the block
	output logic [7:0] ser_in_data_o,
	output logic ser_in_valid_o,
	input wire logic ser_in_ready_i,
	// Bytes from the block
	input wire logic [7:0] ser_out_data_i,
	input wire logic ser_out_valid_i,
	output logic ser_out_ready_o,
	output logic ser_out_active_o
);
	logic [7:0] q[$];
	logic [7:0] rxq[$];
	int shift_cnt;

	// The shifter stays active for three cycles after each byte it takes.
	assign ser_out_active_o = (shift_cnt != 0);

	// The byte on offer is held until taken; idle data toggles so it is never mistaken for a stale byte.
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ser_in_valid_o <= 1'b0;
			ser_in_data_o <= 8'h00;
		end else begin
			if (ser_in_valid_o && ser_in_ready_i) begin
				void'(q.pop_front());
			end
			// The accepted byte has already left the queue, so the front is the next one.
			if (q.size() > 0) begin
				ser_in_valid_o <= 1'b1;
				ser_in_data_o <= q[0];
			end else begin
				ser_in_valid_o <= 1'b0;
				ser_in_data_o <= ~ser_in_data_o;
			end
		end
	end

	// Output bytes are collected; the host refuses while stalled or still shifting.
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ser_out_ready_o <= 1'b0;
			shift_cnt <= 0;
		end else if (ser_out_valid_i && ser_out_ready_o) begin
			rxq.push_back(ser_out_data_i);
			ser_out_ready_o <= 1'b0;
			shift_cnt <= 3;
		end else begin
			ser_out_ready_o <= !stall_i && (shift_cnt == 0);
			if (shift_cnt != 0) begin
				shift_cnt <= shift_cnt - 1;
			end
		end
	end
endmodule : host_model
`default_nettype wire

// ===== sim/tb_top.sv
// Testbench for the busy indicator and mode sequencer.
`timescale 1ns/1ps
`default_nettype none
module tb_top import aux_seq_pkg::*;;
	localparam int SET = 20;
	localparam int INI = 8;
	localparam int TXB = 8;
	localparam int SUB = 4;
	logic clk_i, rst_b_i, rtx_rdy, rrx_v, stall;
	logic [1:0] msel;
	logic [15:0] own;
	radio_rx_t rrx;
	logic [7:0] sin_d, sout_d;
	logic sin_v, sin_r, sout_v, sout_r, sout_a, rtx_v, rrx_r, idle;
	radio_tx_t rtx;
	mode_t mode;
	int err_total, tests_run, cyc_cnt, n;

	aux_status_mode_sequencer #(.SETTLE_CYCLES(SET), .INIT_CYCLES(INI), .TX_BUF_BYTES(TXB),
		.RX_FIFO_WORDS(4), .SUBPKT_BYTES(SUB)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.mode_select_lo_i(msel[0]), .mode_select_hi_i(msel[1]), .own_addr_i(own),
		.ser_in_data_i(sin_d), .ser_in_valid_i(sin_v), .ser_in_ready_o(sin_r),
		.ser_out_data_o(sout_d), .ser_out_valid_o(sout_v), .ser_out_ready_i(sout_r),
		.ser_out_active_i(sout_a), .radio_tx_o(rtx), .radio_tx_valid_o(rtx_v),
		.radio_tx_ready_i(rtx_rdy), .radio_rx_i(rrx), .radio_rx_valid_i(rrx_v),
		.radio_rx_ready_o(rrx_r), .idle_ind_o(idle), .mode_o(mode));
	host_model host (.clk_i(clk_i), .rst_b_i(rst_b_i), .stall_i(stall), .ser_in_data_o(sin_d),
		.ser_in_valid_o(sin_v), .ser_in_ready_i(sin_r), .ser_out_data_i(sout_d),
		.ser_out_valid_i(sout_v), .ser_out_ready_o(sout_r), .ser_out_active_o(sout_a));

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	// Clock at 100 MHz.
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// A hung run is cut short; the ceiling is well above the few hundred cycles the tests need.
	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			err_total++;
			test_done();
		end
	end

	task test_done;
		if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : test_done

	task chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
			err_total++;
		end
	endtask : chk

	task cyc(input int k);
		repeat (k) @(posedge clk_i);
	endtask : cyc

	// Counts cycles until the indicator reads high, with a bound.
	task low_len(output int k);
		k = 0;
		@(negedge clk_i);
		while (idle !== 1'b1 && k < 5000) begin
			k++;
			@(negedge clk_i);
		end
	endtask : low_len

	// Collects radio bytes and checks order, sub-packet ends and the broadcast flag.
	task drain(input int cnt, input logic [7:0] base, input logic bc);
		int i, t;
		logic lst;
		i = 0;
		for (t = 0; t < 300 && i < cnt; t++) begin
			@(negedge clk_i);
			if (rtx_v === 1'b1 && rtx_rdy === 1'b1) begin
				lst = ((i % SUB) == SUB - 1) || (i == cnt - 1);
				chk(rtx.data, base + i);
				chk(rtx.last, lst);
				chk(rtx.broadcast, bc);
				i++;
			end
		end
		chk(i, cnt);
	endtask : drain

	// Offers one radio byte and holds it until the block is ready at an edge.
	task rx_send(input logic [15:0] a, input logic [7:0] d);
		int t;
		@(posedge clk_i);
		rrx <= '{data: d, dest_addr: a};
		rrx_v <= 1'b1;
		t = 0;
		@(negedge clk_i);
		while (rrx_r !== 1'b1 && t < 100) begin
			t++;
			@(negedge clk_i);
		end
		@(posedge clk_i);
		rrx_v <= 1'b0;
		rrx <= ~rrx;
	endtask : rx_send

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	// Indicator low through reset and self-check, then high.
	task t_reset;
		@(negedge clk_i);
		chk(idle, 1'b0);
		chk(mode, 2'b00);
		@(posedge clk_i);
		rst_b_i <= 1'b1;
		low_len(n);
		chk(n >= INI - 1 && n <= INI + 4, 1'b1);
	endtask : t_reset

	// Fill the buffer with the radio stalled, then drain it in sub-packets.
	task t_tx;
		@(posedge clk_i);
		rtx_rdy <= 1'b0;
		@(negedge clk_i);
		for (int i = 0; i < TXB + 1; i++) host.q.push_back(8'h10 + i);
		cyc(40);
		@(negedge clk_i);
		chk(idle, 1'b0);
		chk(sin_r, 1'b0);
		chk(host.q.size(), 1);
		@(posedge clk_i);
		rtx_rdy <= 1'b1;
		drain(TXB + 1, 8'h10, 1'b0);
		low_len(n);
		chk(idle, 1'b1);
		chk(sin_r, 1'b1);
		@(posedge clk_i);
		own <= 16'hffff;
		@(negedge clk_i);
		host.q.push_back(8'h55);
		drain(1, 8'h55, 1'b1);
		@(posedge clk_i);
		own <= 16'h1234;
	endtask : t_tx

	// Received bytes are filtered by address and hold the indicator low until output.
	task t_rx;
		@(posedge clk_i);
		stall <= 1'b1;
		rx_send(16'h1234, 8'ha1);
		rx_send(16'h5678, 8'ha2);
		rx_send(16'hffff, 8'ha3);
		cyc(6);
		@(negedge clk_i);
		chk(idle, 1'b0);
		chk(sout_v, 1'b1);
		@(posedge clk_i);
		stall <= 1'b0;
		low_len(n);
		chk(host.rxq.size(), 2);
		chk(host.rxq[0], 8'ha1);
		chk(host.rxq[1], 8'ha3);
		@(posedge clk_i);
		own <= 16'hffff;
		rx_send(16'h5678, 8'hb4);
		cyc(4);
		low_len(n);
		chk(host.rxq.size(), 3);
		chk(host.rxq[2], 8'hb4);
		@(posedge clk_i);
		own <= 16'h1234;
	endtask : t_rx

	// Mode change held off while busy, then every mode applied, sleep exit reloading.
	task t_mode;
		logic [1:0] seq [5];
		logic [1:0] prev;
		int t;
		seq = '{2'b10, 2'b00, 2'b11, 2'b01, 2'b00};
		@(posedge clk_i);
		rtx_rdy <= 1'b0;
		@(negedge clk_i);
		host.q.push_back(8'h77);
		cyc(6);
		msel <= 2'b01;
		cyc(10);
		@(negedge clk_i);
		chk(mode, 2'b00);
		@(posedge clk_i);
		rtx_rdy <= 1'b1;
		low_len(n);
		t = 0;
		while (mode !== 2'b01 && t < 1000) begin
			t++;
			@(negedge clk_i);
		end
		chk(t >= SET - 3 && t <= SET + 4, 1'b1);
		prev = 2'b01;
		for (int k = 0; k < 5; k++) begin
			cyc(SET + 5);
			msel <= seq[k];
			t = 0;
			@(negedge clk_i);
			while (mode !== seq[k] && t < 20) begin
				t++;
				@(negedge clk_i);
			end
			chk(mode, seq[k]);
			chk(t >= 2 && t <= 6, 1'b1);
			if (prev == 2'b11) begin
				@(negedge clk_i);
				@(negedge clk_i);
				chk(idle, 1'b0);
				low_len(n);
				chk(n >= INI - 3 && n <= INI + 4, 1'b1);
			end else begin
				cyc(4);
				@(negedge clk_i);
				chk(idle, 1'b1);
			end
			prev = seq[k];
		end
	endtask : t_mode

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	// Inputs get values at time zero; reset is held for two cycles.
	initial begin
		err_total = 0;
		tests_run = 0;
		cyc_cnt = 0;
		rst_b_i = 1'b0;
		rtx_rdy = 1'b0;
		rrx_v = 1'b0;
		rrx = '0;
		stall = 1'b0;
		msel = 2'b00;
		own = 16'h1234;
		cyc(1);
		t_reset();
		t_tx();
		t_rx();
		t_mode();
		test_done();
	end
endmodule : tb_top
`default_nettype wire
